// [hdl/asti_pkg.sv]
/*
 * Constants, codes and carriers for the asynchronous serial terminal interface.
 * Assumes a 20 MHz mclk and an I/O bus front end that decodes instructions into
 * one-cycle strobes carrying device code, instruction type and flag function.
 */
//
// Behaviour
// R1: Receiver start sets busy, clear clears both
// R2: Receiver pulse clears done and break bit
// R3: Transmit start: busy, RTS, send after CTS
// R4: Transmit clear: flags off, stop, drop RTS
// R5: Transmit pulse clears only done
// R6: Flag function follows the data transfer
// R7: Read character: bits 8-15, upper zero
// R8: Write character loads bits 8-15 only
// R9: Modem status in bits 12-15, rest zero
// R10: Break bit sets on spacing line, sticky
// R11: Terminal ready follows bit 15
// R12: Device codes jumpered, low bit fixed
// R13: Debug memory enabled only by jumper
// R14: CTS ignore jumper skips the wait
// R15: Transmit end sets done, interrupt request
// R16: Receiver assembles character, sets done, interrupts
// R17: Next character overwrites the receive buffer
// R18: Frame 5-8 data bits, parity, stops
// R19: Fourteen rates selected by four jumpers
// R20: Length, parity, stops configure both directions; the receiver ignores the stop jumper and checks one stop bit
`default_nettype none

package asti_pkg;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned BRK_CHARS = 2; // Character times of space that mean break

	// ********************************************************************
	// Bus codes
	// ********************************************************************
	typedef enum logic [2:0] {
		ASTI_IO_NIO,
		ASTI_IO_DIA,
		ASTI_IO_DOA,
		ASTI_IO_DIB,
		ASTI_IO_DOB
	} asti_io_type;

	typedef enum logic [1:0] {
		ASTI_F_NONE,
		ASTI_F_START,
		ASTI_F_CLEAR,
		ASTI_F_PULSE
	} asti_flag_type;

	typedef struct packed {
		logic strobe;
		logic [5:0] code;
		asti_io_type op;
		asti_flag_type fn;
		logic [15:0] data;
	} asti_req_type;

	typedef struct packed {
		logic [4:0] rx_code;
		logic [4:0] tx_code;
		logic [3:0] baud;
		logic [1:0] len;
		logic par_en;
		logic par_odd;
		logic stop_one;
		logic debug_en;
		logic cts_ignore;
	} asti_cfg_type;

	// ********************************************************************
	// Register layout
	// ********************************************************************
	localparam int unsigned CHAR_LSB = 0;
	localparam int unsigned STAT_CD = 3;
	localparam int unsigned STAT_DSR = 2;
	localparam int unsigned STAT_RING = 1;
	localparam int unsigned STAT_BRK = 0;
	localparam int unsigned DTR_BIT = 0;
	localparam logic RX_CODE_LSB = 1'b0;
	localparam logic TX_CODE_LSB = 1'b1;
	localparam logic [7:0] DEBUG_BASE_HI = 8'hfe;

	// Clocks per oversample tick for a jumper code, zero if unused
	function automatic logic [15:0] asti_div(input logic [3:0] sel);
		int unsigned baud_x10;
		baud_x10 = 0;
		unique case (sel)
			4'hd: baud_x10 = 500;
			4'hc: baud_x10 = 750;
			4'h0: baud_x10 = 1100;
			4'hb: baud_x10 = 1345;
			4'h1: baud_x10 = 1500;
			4'ha: baud_x10 = 2000;
			4'h2: baud_x10 = 3000;
			4'h9: baud_x10 = 6000;
			4'h4: baud_x10 = 12000;
			4'h5: baud_x10 = 18000;
			4'h3: baud_x10 = 24000;
			4'h6: baud_x10 = 48000;
			4'h7: baud_x10 = 96000;
			4'he: baud_x10 = 192000;
			default: baud_x10 = 0;
		endcase
		if (baud_x10 == 0) begin
			return 16'h0000;
		end
		return 16'((longint'(CLK_HZ) * 10) / (longint'(baud_x10) * OVERSAMPLE));
	endfunction

endpackage

`default_nettype wire

// [hdl/asti_top.sv]
/*
 * Full-duplex serial terminal controller: receiver and transmitter units with
 * busy/done flags, modem lines and a jumper-enabled debug memory select.
 * Assumes bus requests arrive as one-cycle strobes on mclk; serial and modem
 * inputs are asynchronous and are synchronised here.
 */
`default_nettype none

module asti_top (
	input wire logic mclk,
	input wire logic srst,
	input wire asti_pkg::asti_req_type req,
	input wire asti_pkg::asti_cfg_type cfg,
	input wire logic [7:0] mem_addr_hi,
	input wire logic serial_in,
	input wire logic cts_in,
	input wire logic cd_in,
	input wire logic dsr_in,
	input wire logic ring_in,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic serial_out,
	output logic rts_out,
	output logic dtr_out,
	output logic rx_busy,
	output logic rx_done,
	output logic tx_busy,
	output logic tx_done,
	output logic irq_rx,
	output logic irq_tx,
	output logic debug_sel
);
	import asti_pkg::*;

	// ********************************************************************
	// Input synchronisers
	// ********************************************************************
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic rxd;
	logic cts;

	// Two stages on every pin; only the second stage is read
	always_ff @(posedge mclk) begin
		sync1_q <= {serial_in, cts_in, cd_in, dsr_in, ring_in};
		sync2_q <= sync1_q;
	end
	assign rxd = sync2_q[4];
	assign cts = sync2_q[3];

	// ********************************************************************
	// Address decode
	// ********************************************************************
	logic hit_rx;
	logic hit_tx;
	assign hit_rx = req.strobe && req.code == {cfg.rx_code, RX_CODE_LSB}; // see R12
	assign hit_tx = req.strobe && req.code == {cfg.tx_code, TX_CODE_LSB}; // see R12

	// ********************************************************************
	// Baud tick, shared by both directions
	// ********************************************************************
	logic [15:0] div_cnt_q;
	logic tick;
	logic [15:0] div_n;
	assign div_n = asti_div(cfg.baud); // see R19
	assign tick = div_n != 16'h0000 && div_cnt_q == 16'h0000;

	always_ff @(posedge mclk) begin
		if (srst || tick || div_cnt_q >= div_n) begin
			div_cnt_q <= div_n - 16'h0001;
		end else if (div_n != 16'h0000) begin
			div_cnt_q <= div_cnt_q - 16'h0001;
		end
	end

	// Data bits per character from the length jumpers (both directions)
	logic [3:0] nbits;
	assign nbits = 4'h5 + {2'b00, cfg.len}; // see R20

	// ********************************************************************
	// Transmitter
	// ********************************************************************
	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} asti_tx_type;
	asti_tx_type tx_st_q;
	logic [7:0] tx_buf_q;
	logic [7:0] tx_sh_q;
	logic [3:0] tx_os_q;
	logic [3:0] tx_bit_q;
	logic tx_par_q;
	logic tx_bit_end;
	assign tx_bit_end = tick && tx_os_q == 4'hf;

	// Buffer written before the flag function acts
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_buf_q <= 8'h00;
		end else if (hit_tx && req.op == ASTI_IO_DOA) begin
			tx_buf_q <= req.data[7:0]; // see R8
		end
	end

	// Character framing; start and clear act after the buffer load, see R6
	always_ff @(posedge mclk) begin
		if (srst || (hit_tx && req.fn == ASTI_F_CLEAR)) begin
			tx_st_q <= TX_IDLE; // see R4
			tx_os_q <= 4'h0;
			tx_bit_q <= 4'h0;
			tx_sh_q <= 8'h00;
			tx_par_q <= 1'b0;
		end else if (hit_tx && req.fn == ASTI_F_START) begin
			tx_st_q <= TX_WAIT; // see R3
		end else begin
			if (tick) begin
				tx_os_q <= tx_os_q + 4'h1;
			end
			unique case (tx_st_q)
				TX_IDLE: tx_os_q <= 4'h0;
				TX_WAIT: begin
					tx_os_q <= 4'h0;
					if (cts || cfg.cts_ignore) begin // see R3, see R14
						tx_st_q <= TX_START;
						tx_sh_q <= tx_buf_q;
						tx_par_q <= cfg.par_odd;
						tx_bit_q <= 4'h0;
					end
				end
				TX_START: if (tx_bit_end) tx_st_q <= TX_DATA;
				TX_DATA: if (tx_bit_end) begin
					tx_par_q <= tx_par_q ^ tx_sh_q[0];
					tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					tx_bit_q <= tx_bit_q + 4'h1;
					if (tx_bit_q == nbits - 4'h1) begin // see R18
						tx_st_q <= cfg.par_en ? TX_PAR : TX_STOP;
						tx_bit_q <= 4'h0;
					end
				end
				TX_PAR: if (tx_bit_end) tx_st_q <= TX_STOP;
				TX_STOP: if (tx_bit_end) begin
					tx_bit_q <= tx_bit_q + 4'h1;
					if (cfg.stop_one || tx_bit_q == 4'h1) begin
						tx_st_q <= TX_IDLE;
					end
				end
			endcase
		end
	end

	logic tx_finish;
	assign tx_finish = tx_st_q == TX_STOP && tx_bit_end && (cfg.stop_one || tx_bit_q == 4'h1);

	// Line drive registered for a glitch-free pin
	always_ff @(posedge mclk) begin
		if (srst) begin
			serial_out <= 1'b1;
		end else begin
			unique case (tx_st_q)
				TX_START: serial_out <= 1'b0;
				TX_DATA: serial_out <= tx_sh_q[0];
				TX_PAR: serial_out <= tx_par_q;
				default: serial_out <= 1'b1;
			endcase
		end
	end

	// Transmitter flags; completion outranks a same-cycle pulse
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_busy <= 1'b0;
			tx_done <= 1'b0;
			rts_out <= 1'b0;
			irq_tx <= 1'b0;
		end else begin
			irq_tx <= tx_finish; // see R15
			if (hit_tx && req.fn == ASTI_F_START) begin
				tx_busy <= 1'b1; // see R3
				tx_done <= 1'b0;
				rts_out <= 1'b1;
			end else if (hit_tx && req.fn == ASTI_F_CLEAR) begin
				tx_busy <= 1'b0; // see R4
				tx_done <= 1'b0;
				rts_out <= 1'b0;
			end else if (tx_finish) begin
				tx_busy <= 1'b0; // see R15
				tx_done <= 1'b1;
			end else if (hit_tx && req.fn == ASTI_F_PULSE) begin
				tx_done <= 1'b0; // see R5
			end
		end
	end

	// Terminal ready follows the control word
	always_ff @(posedge mclk) begin
		if (srst) begin
			dtr_out <= 1'b0;
		end else if (hit_tx && req.op == ASTI_IO_DOB) begin
			dtr_out <= req.data[DTR_BIT]; // see R11
		end
	end

	// ********************************************************************
	// Receiver
	// ********************************************************************
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_MARK} asti_rx_type;
	asti_rx_type rx_st_q;
	logic [7:0] rx_sh_q;
	logic [7:0] rx_buf_q;
	logic [3:0] rx_os_q;
	logic [3:0] rx_bit_q;
	logic rx_mid;
	logic rx_got;
	logic [7:0] rx_aligned;
	assign rx_mid = tick && rx_os_q == 4'h7;
	assign rx_got = rx_st_q == RX_STOP && rx_mid && rxd;
	// Right-justify short characters, see R7
	assign rx_aligned = rx_sh_q >> (4'h8 - nbits);

	// Oversampled receive; parity bit sampled and skipped
	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_st_q <= RX_IDLE;
			rx_os_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
		end else begin
			if (tick) begin
				rx_os_q <= rx_os_q + 4'h1;
			end
			unique case (rx_st_q)
				RX_IDLE: begin
					rx_os_q <= 4'h0;
					if (!rxd) rx_st_q <= RX_START; // see R16
				end
				RX_START: if (rx_mid) begin
					rx_os_q <= 4'h8;
					rx_bit_q <= 4'h0;
					rx_st_q <= rxd ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rx_mid) begin
					rx_bit_q <= rx_bit_q + 4'h1;
					if (rx_bit_q < nbits) begin
						rx_sh_q <= {rxd, rx_sh_q[7:1]};
					end
					if (rx_bit_q == nbits - {3'b000, ~cfg.par_en}) begin
						rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: if (rx_mid) begin
					rx_st_q <= rxd ? RX_IDLE : RX_MARK;
				end
				// A framing error or a break waits for mark and never sets done
				RX_MARK: if (rxd) rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Buffer overwritten by each new character, see R17
	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_buf_q <= 8'h00;
		end else if (rx_got) begin
			rx_buf_q <= rx_aligned; // see R16
		end
	end

	// Receiver flags; arrival of a character wins over a same-cycle clear
	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_busy <= 1'b0;
			rx_done <= 1'b0;
			irq_rx <= 1'b0;
		end else begin
			irq_rx <= rx_got; // see R16
			if (rx_got) begin
				rx_done <= 1'b1;
				rx_busy <= 1'b0;
			end else if (hit_rx && req.fn == ASTI_F_START) begin
				rx_busy <= 1'b1; // see R1
				rx_done <= 1'b0;
			end else if (hit_rx && req.fn == ASTI_F_CLEAR) begin
				rx_busy <= 1'b0; // see R1
				rx_done <= 1'b0;
			end else if (hit_rx && req.fn == ASTI_F_PULSE) begin
				rx_done <= 1'b0; // see R2
			end
		end
	end

	// Break: line spacing for BRK_CHARS x 16 bit times of ticks
	logic [11:0] brk_cnt_q;
	logic brk_q;
	always_ff @(posedge mclk) begin
		if (srst || rxd) begin
			brk_cnt_q <= 12'h000;
		end else if (tick && brk_cnt_q != 12'hfff) begin
			brk_cnt_q <= brk_cnt_q + 12'h001;
		end
	end

	// Detection wins over the pulse clear
	always_ff @(posedge mclk) begin
		if (srst) begin
			brk_q <= 1'b0;
		end else if (brk_cnt_q >= 12'(BRK_CHARS * 16 * OVERSAMPLE)) begin
			brk_q <= 1'b1; // see R10
		end else if (hit_rx && req.fn == ASTI_F_PULSE) begin
			brk_q <= 1'b0; // see R2
		end
	end

	// ********************************************************************
	// Read data path
	// ********************************************************************
	// Data is captured from state before the flag function of the same strobe acts, see R6
	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= hit_rx && (req.op == ASTI_IO_DIA || req.op == ASTI_IO_DIB);
			if (hit_rx && req.op == ASTI_IO_DIA) begin
				rd_data <= {8'h00, rx_buf_q}; // see R7
			end else if (hit_rx && req.op == ASTI_IO_DIB) begin
				rd_data <= {12'h000, sync2_q[2], sync2_q[1], sync2_q[0], brk_q}; // see R9
			end else begin
				rd_data <= 16'h0000;
			end
		end
	end

	// ********************************************************************
	// Debug memory select
	// ********************************************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			debug_sel <= 1'b0;
		end else begin
			debug_sel <= cfg.debug_en && mem_addr_hi == DEBUG_BASE_HI; // see R13
		end
	end

endmodule

`default_nettype wire

// [test/asti_assertions.sv]
/* Port checker for asti_top.
 * Assumes static cfg and a bind from the bench top. */
`default_nettype none
module asti_assertions import asti_pkg::*; (
	input wire logic mclk,
	input wire logic srst,
	input wire asti_pkg::asti_req_type req,
	input wire asti_pkg::asti_cfg_type cfg,
	input wire logic [7:0] mem_addr_hi,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic rts_out,
	input wire logic dtr_out,
	input wire logic tx_busy,
	input wire logic tx_done,
	input wire logic debug_sel
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rx_ok;
	logic tx_ok;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	// Accepted requests only; wrong unit or wrong code is ignored
	assign rx_ok = req.strobe && req.code == {cfg.rx_code, RX_CODE_LSB};
	assign tx_ok = req.strobe && req.code == {cfg.tx_code, TX_CODE_LSB};
	property p_tx_start;
		tx_ok && req.fn == ASTI_F_START |=> tx_busy && !tx_done && rts_out;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("tx start");
	property p_tx_clear;
		tx_ok && req.fn == ASTI_F_CLEAR |=> !tx_busy && !tx_done && !rts_out;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx clear");
	// Completion may win over a pulse in the same cycle
	property p_tx_pulse;
		tx_ok && req.fn == ASTI_F_PULSE |=> $stable(rts_out) && (tx_done ? $rose(tx_done) : $stable(tx_busy));
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("tx pulse");
	property p_read_char;
		rx_ok && req.op == ASTI_IO_DIA |=> rd_valid && rd_data[15:8] == 8'h00;
	endproperty
	a_read_char: assert property (p_read_char) else $error("read char");
	property p_status;
		rx_ok && req.op == ASTI_IO_DIB |=> rd_valid && rd_data[15:4] == 12'h000;
	endproperty
	a_status: assert property (p_status) else $error("status");
	property p_dtr;
		tx_ok && req.op == ASTI_IO_DOB |=> dtr_out == $past(req.data[DTR_BIT])
			##1 ($stable(dtr_out) || $past(tx_ok && req.op == ASTI_IO_DOB));
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr");
	property p_answer;
		rd_valid |-> $past(rx_ok && req.op inside {ASTI_IO_DIA, ASTI_IO_DIB});
	endproperty
	a_answer: assert property (p_answer) else $error("stray answer");
	property p_debug;
		1'b1 |=> debug_sel == $past(cfg.debug_en && mem_addr_hi == DEBUG_BASE_HI);
	endproperty
	a_debug: assert property (p_debug) else $error("debug select");
	c_tx: cover property ($fell(tx_busy));
	c_brk: cover property (rd_valid && rd_data[STAT_BRK]);
	c_dbg: cover property (debug_sel);
endmodule
`default_nettype wire

// [test/asti_term_model.sv]
/* Terminal and modem model on the serial pins.
 * Assumes BIT_CLK mclk cycles a bit, 8 data bits, no parity, one stop. */
`default_nettype none
module asti_term_model #(
	parameter int BIT_CLK = 1040
) (
	input wire logic mclk,
	input wire logic serial_out,
	input wire logic rts_out,
	output logic serial_in,
	output logic cts_in,
	output logic cd_in,
	output logic dsr_in,
	output logic ring_in
);
	timeunit 1ns;
	timeprecision 1ns;
	int cts_wait = 4;
	int cnt = 0;
	initial begin
		serial_in = 1'b1;
		cts_in = 1'b0;
		cd_in = 1'b0;
		dsr_in = 1'b0;
		ring_in = 1'b0;
	end
	// Grant clear to send a set time after the request; a slow modem stalls
	always @(negedge mclk) begin
		cnt <= rts_out ? cnt + 1 : 0;
		cts_in <= rts_out && cnt >= cts_wait;
	end
	// Start bit, data LSB first, one stop bit
	task automatic send_char(input logic [7:0] ch);
		logic [9:0] f;
		f = {1'b1, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_in = f[i];
			repeat (BIT_CLK) @(negedge mclk);
		end
	endtask
	task automatic hold_space(input int cycles);
		serial_in = 1'b0;
		repeat (cycles) @(negedge mclk);
		serial_in = 1'b1;
	endtask
	// Samples mid bit; returns data and the stop level
	task automatic recv_char(output logic [7:0] ch, output logic stop);
		@(negedge serial_out);
		repeat (BIT_CLK + BIT_CLK / 2) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			ch[i] = serial_out;
			repeat (BIT_CLK) @(negedge mclk);
		end
		stop = serial_out;
	endtask
endmodule
`default_nettype wire

// [test/tb.sv]
/* Bench for asti_top: bus tasks, terminal model, checks.
 * Assumes baud code e, so 1040 mclk cycles a bit. */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import asti_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	asti_req_type req = '0;
	asti_cfg_type cfg = '{5'h05, 5'h06, 4'he, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [7:0] mem_addr_hi = 8'h00;
	logic serial_in, cts_in, cd_in, dsr_in, ring_in;
	logic [15:0] rd_data;
	logic rd_valid, serial_out, rts_out, dtr_out, rx_busy, rx_done;
	logic tx_busy, tx_done, irq_rx, irq_tx, debug_sel;
	int err_count = 0;
	int samples_checked = 0;
	logic [7:0] c;
	logic s;
	int n;
	always #25 mclk = ~mclk;
	asti_top dut_u (.mclk(mclk), .srst(srst), .req(req), .cfg(cfg), .mem_addr_hi(mem_addr_hi),
		.serial_in(serial_in), .cts_in(cts_in), .cd_in(cd_in), .dsr_in(dsr_in), .ring_in(ring_in),
		.rd_data(rd_data), .rd_valid(rd_valid), .serial_out(serial_out), .rts_out(rts_out),
		.dtr_out(dtr_out), .rx_busy(rx_busy), .rx_done(rx_done), .tx_busy(tx_busy), .tx_done(tx_done),
		.irq_rx(irq_rx), .irq_tx(irq_tx), .debug_sel(debug_sel));
	asti_term_model term_u (.mclk(mclk), .serial_out(serial_out), .rts_out(rts_out), .serial_in(serial_in),
		.cts_in(cts_in), .cd_in(cd_in), .dsr_in(dsr_in), .ring_in(ring_in));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One-cycle strobe from a falling edge; answer is visible on return.
	// An edge passes first so back-to-back calls never drop and raise strobe at once.
	task automatic bus(input logic tx, input asti_io_type op, input asti_flag_type fn, input logic [15:0] d);
		@(negedge mclk);
		req = '{1'b1, tx ? {cfg.tx_code, 1'b1} : {cfg.rx_code, 1'b0}, op, fn, d};
		@(negedge mclk);
		req.strobe = 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog: the sequence needs about 84000 cycles
	initial begin
		repeat (95000) @(posedge mclk);
		err_count++;
		complete_run();
	end
	initial begin
		repeat (16) @(negedge mclk);
		srst = 1'b0;
		chk(16'({serial_out, rts_out, dtr_out, tx_busy, tx_done, rx_busy, rx_done}), 16'h0040, "reset");
		bus(1, ASTI_IO_DOB, ASTI_F_NONE, 16'h0001);
		chk(16'(dtr_out), 16'h0001, "dtr on");
		bus(1, ASTI_IO_DOB, ASTI_F_NONE, 16'hfffe);
		chk(16'(dtr_out), 16'h0000, "dtr off");
		term_u.cd_in = 1'b1;
		term_u.ring_in = 1'b1;
		repeat (4) @(negedge mclk);
		bus(0, ASTI_IO_DIB, ASTI_F_NONE, 16'h0000);
		chk(rd_data, 16'h000a, "status");
		bus(1, ASTI_IO_DIA, ASTI_F_NONE, 16'h0000);
		chk(16'(rd_valid), 16'h0000, "wrong unit");
		// Slow modem: the line must stay idle until clear to send
		term_u.cts_wait = 3000;
		fork
			term_u.recv_char(c, s);
			begin
				bus(1, ASTI_IO_DOA, ASTI_F_START, 16'hff55);
				chk(16'({tx_busy, tx_done, rts_out}), 16'h0005, "tx start");
				repeat (2000) @(negedge mclk);
				chk(16'(serial_out), 16'h0001, "cts wait");
			end
		join
		chk(16'({c, s}), 16'h00ab, "frame");
		// Polled on every falling edge, so the one-cycle request is still up
		for (n = 0; n < 3000 && tx_done !== 1'b1; n++) @(negedge mclk);
		chk(16'({tx_busy, tx_done, irq_tx}), 16'h0003, "tx end");
		bus(1, ASTI_IO_NIO, ASTI_F_PULSE, 16'h0000);
		chk(16'(tx_done), 16'h0000, "tx pulse");
		bus(1, ASTI_IO_DOA, ASTI_F_START, 16'h0031);
		repeat (20) @(negedge mclk);
		bus(1, ASTI_IO_NIO, ASTI_F_CLEAR, 16'h0000);
		chk(16'({tx_busy, tx_done, rts_out}), 16'h0000, "tx clear");
		repeat (4000) @(negedge mclk);
		chk(16'({serial_out, tx_done}), 16'h0002, "tx stopped");
		cfg.cts_ignore = 1'b1;
		term_u.cts_wait = 200000;
		fork
			term_u.recv_char(c, s);
			begin
				bus(1, ASTI_IO_DOA, ASTI_F_START, 16'h00c3);
				repeat (100) @(negedge mclk);
				bus(1, ASTI_IO_NIO, ASTI_F_PULSE, 16'h0000);
				chk(16'({tx_busy, rts_out}), 16'h0003, "pulse busy");
			end
		join
		chk(16'(c), 16'h00c3, "no cts");
		for (n = 0; n < 3000 && tx_done !== 1'b1; n++) @(negedge mclk);
		chk(16'({tx_busy, tx_done, irq_tx}), 16'h0003, "tx end no cts");
		cfg.cts_ignore = 1'b0;
		term_u.send_char(8'h5a);
		fork
			term_u.send_char(8'ha3);
			begin
				for (n = 0; n < 12000 && irq_rx !== 1'b1; n++) @(negedge mclk);
				chk(16'({irq_rx, rx_done}), 16'h0003, "rx irq");
			end
		join
		chk(16'(rx_done), 16'h0001, "rx done");
		bus(0, ASTI_IO_DIA, ASTI_F_PULSE, 16'h0000);
		chk(rd_data, 16'h00a3, "rx char");
		chk(16'(rx_done), 16'h0000, "rx pulse");
		bus(0, ASTI_IO_NIO, ASTI_F_START, 16'h0000);
		chk(16'({rx_busy, rx_done}), 16'h0002, "rx start");
		bus(0, ASTI_IO_NIO, ASTI_F_CLEAR, 16'h0000);
		chk(16'({rx_busy, rx_done}), 16'h0000, "rx clear");
		term_u.hold_space(34500);
		repeat (100) @(negedge mclk);
		bus(0, ASTI_IO_DIB, ASTI_F_PULSE, 16'h0000);
		chk(rd_data, 16'h000b, "break");
		bus(0, ASTI_IO_DIB, ASTI_F_NONE, 16'h0000);
		chk(rd_data, 16'h000a, "break clear");
		mem_addr_hi = 8'hfe;
		repeat (2) @(negedge mclk);
		chk(16'(debug_sel), 16'h0000, "debug off");
		cfg.debug_en = 1'b1;
		repeat (2) @(negedge mclk);
		chk(16'(debug_sel), 16'h0001, "debug on");
		complete_run();
	end
endmodule
bind asti_top asti_assertions chk_u (.mclk(mclk), .srst(srst), .req(req), .cfg(cfg), .mem_addr_hi(mem_addr_hi),
	.rd_data(rd_data), .rd_valid(rd_valid), .rts_out(rts_out), .dtr_out(dtr_out), .tx_busy(tx_busy),
	.tx_done(tx_done), .debug_sel(debug_sel));
`default_nettype wire
